/* core/pwm_shutdown_pkg.sv */
// Constants and register map of the PWM auto-shutdown block
package pwm_shutdown_pkg;
  localparam int UNITS = 3;
  localparam int ADDR_W = 16;
  // Register indices as laid out; byte address is four times the index
  localparam logic [13:0] IDX_CTRL_UNIT1 = 14'h0FBE;
  localparam logic [13:0] IDX_CTRL_UNIT2 = 14'h0FB8;
  localparam logic [13:0] IDX_CTRL_UNIT3 = 14'h0F19;
  localparam logic [15:0] ADDR_CTRL_UNIT1 = {IDX_CTRL_UNIT1, 2'b00};
  localparam logic [15:0] ADDR_CTRL_UNIT2 = {IDX_CTRL_UNIT2, 2'b00};
  localparam logic [15:0] ADDR_CTRL_UNIT3 = {IDX_CTRL_UNIT3, 2'b00};
  // Additional registers
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0000;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0004;
  localparam logic [15:0] ADDR_RESTART_CTRL = 16'h0008;
  localparam logic [15:0] ADDR_PERIOD = 16'h000C;
  localparam logic [15:0] ADDR_DUTY_UNIT1 = 16'h0010;
  localparam logic [15:0] ADDR_DUTY_UNIT2 = 16'h0014;
  localparam logic [15:0] ADDR_DUTY_UNIT3 = 16'h0018;
  // Control register fields
  localparam int FLAG_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int AC_LSB = 2;
  localparam int BD_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  // Source select codes
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_CMP1 = 3'h1;
  localparam logic [2:0] SRC_CMP2 = 3'h2;
  localparam logic [2:0] SRC_CMP_ANY = 3'h3;
  localparam logic [2:0] SRC_FLT = 3'h4;
  localparam logic [2:0] SRC_FLT_CMP1 = 3'h5;
  localparam logic [2:0] SRC_FLT_CMP2 = 3'h6;
  localparam logic [2:0] SRC_FLT_ANY = 3'h7;
  // Pair shutdown level codes
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  typedef enum logic [1:0] {BUS_WAIT = 2'b01, BUS_ACK = 2'b10} bus_state_t;
endpackage

/* core/pwm_period_gen.sv */
// Free-running PWM period counter with one duty compare per unit
`timescale 1ns/1ns
module pwm_period_gen
  import pwm_shutdown_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Settings
  input wire logic [7:0] period,
  input wire logic [UNITS-1:0][7:0] duty,
  // Outputs
  output logic period_start,
  output logic [UNITS-1:0] raw_a
);
  typedef struct packed {
    logic [7:0] count;
    logic start;
    logic [UNITS-1:0] a;
  } gen_state_t;

  gen_state_t cur;
  gen_state_t next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.start = 1'b0;
    if (cur.count >= period)
    begin
      next_cur.count = 8'h00;
      next_cur.start = 1'b1;
    end
    else
    begin
      next_cur.count = cur.count + 8'h01;
    end
    for (int u = 0; u < UNITS; u++)
    begin
      next_cur.a[u] = next_cur.count < duty[u];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign period_start = cur.start;
  assign raw_a = cur.a;
endmodule

/* core/shutdown_pin_ctrl.sv */
// Source decode and pin override for one auto-shutdown unit
`timescale 1ns/1ns
module shutdown_pin_ctrl
  import pwm_shutdown_pkg::*;
(
  // Configuration
  input wire logic [2:0] source_select,
  input wire logic [1:0] pair_ac_shutdown_level,
  input wire logic [1:0] pair_bd_shutdown_level,
  // Fault sources
  input wire logic comparator1_result,
  input wire logic comparator2_result,
  input wire logic fault_input_pin,
  // State from the control logic
  input wire logic latched_shutdown,
  input wire logic raw_a,
  // Results
  output logic condition,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);
  logic fault_low;
  logic forced;

  assign fault_low = ~fault_input_pin;

  always_comb
  begin
    case (source_select)
      SRC_OFF: condition = 1'b0;
      SRC_CMP1: condition = comparator1_result;
      SRC_CMP2: condition = comparator2_result;
      SRC_CMP_ANY: condition = comparator1_result | comparator2_result;
      SRC_FLT: condition = fault_low;
      SRC_FLT_CMP1: condition = fault_low | comparator1_result;
      SRC_FLT_CMP2: condition = fault_low | comparator2_result;
      SRC_FLT_ANY: condition = fault_low | comparator1_result | comparator2_result;
      default: condition = 1'b0;
    endcase
  end

  // Live condition overrides pins without waiting for an edge
  assign forced = condition | latched_shutdown;

  // Pin order a, b, c, d; a/c share one level, b/d the other
  always_comb
  begin
    pin_out = {~raw_a, raw_a, ~raw_a, raw_a};
    pin_oe = 4'hF;
    if (forced)
    begin
      pin_out[0] = pair_ac_shutdown_level == LVL_HIGH;
      pin_out[2] = pair_ac_shutdown_level == LVL_HIGH;
      pin_oe[0] = ~pair_ac_shutdown_level[1];
      pin_oe[2] = ~pair_ac_shutdown_level[1];
      pin_out[1] = pair_bd_shutdown_level == LVL_HIGH;
      pin_out[3] = pair_bd_shutdown_level == LVL_HIGH;
      pin_oe[1] = ~pair_bd_shutdown_level[1];
      pin_oe[3] = ~pair_bd_shutdown_level[1];
    end
  end
endmodule

/* core/pwm_auto_shutdown.sv */
// Three-unit PWM auto-shutdown block with Avalon-MM register slave
// Summary of operation
// - A shutdown event sets the unit's shutdown flag, which stays set until firmware or auto-restart clears it.
// - A shutdown event forces the enabled PWM pins to their shutdown states at once, without waiting for a clock.
// - Pins a/c and b/d form two pairs, each taking its shutdown level from its own two-bit field in bits 3:0.
// - Source select 000 is off, 001/010/011 pick comparator 1, 2 or either, 1xx adds a low fault pin to those.
// - The a/c level field gives 00 low, 01 high, and high impedance when its upper bit is set.
// - The b/d level field in bits 1:0 gives 00 low, 01 high, and high impedance when its upper bit is set.
// - Shutdown is set by the level of the selected source and latches, lasting until the flag clears and the next period starts.
// - Software writes to the shutdown flag are ignored while the shutdown condition is still active.
// - After the condition clears and the PWM restarts, output resumes only at the next period start.
// - The shutdown flag reads in bit 7, one from a shutdown event until the flag clears, and zero while the outputs run normally or wait for the next period start.
`timescale 1ns/1ns
module pwm_auto_shutdown
  import pwm_shutdown_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fault sources
  input wire logic comparator1_result,
  input wire logic comparator2_result,
  input wire logic fault_input_pin,
  // PWM pins, one bit per unit
  output logic [UNITS-1:0] pwm_out_a,
  output logic [UNITS-1:0] pwm_out_a_oe,
  output logic [UNITS-1:0] pwm_out_b,
  output logic [UNITS-1:0] pwm_out_b_oe,
  output logic [UNITS-1:0] pwm_out_c,
  output logic [UNITS-1:0] pwm_out_c_oe,
  output logic [UNITS-1:0] pwm_out_d,
  output logic [UNITS-1:0] pwm_out_d_oe,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    bus_state_t bus;
    logic waitrequest;
    logic [31:0] readdata;
    logic [UNITS-1:0][6:0] ctrl;
    logic [UNITS-1:0] shutdown_event_flag;
    logic [UNITS-1:0] hold;
    logic [UNITS-1:0] irq_status;
    logic [UNITS-1:0] irq_mask;
    logic [UNITS-1:0] auto_restart;
    logic [7:0] period;
    logic [UNITS-1:0][7:0] duty;
    logic irq;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;

  logic period_start;
  logic [UNITS-1:0] raw_a;
  logic [UNITS-1:0] condition;
  logic [UNITS-1:0][3:0] pin_out;
  logic [UNITS-1:0][3:0] pin_oe;
  logic [UNITS-1:0][7:0] duty_bus;

  // Decode of a unit's control register, shared by read and write paths
  function automatic logic is_ctrl(input logic [ADDR_W-1:0] addr, input int unit);
    logic hit;
    hit = 1'b0;
    if (unit == 0)
    begin
      hit = addr == ADDR_CTRL_UNIT1;
    end
    else if (unit == 1)
    begin
      hit = addr == ADDR_CTRL_UNIT2;
    end
    else if (unit == 2)
    begin
      hit = addr == ADDR_CTRL_UNIT3;
    end
    return hit;
  endfunction

  function automatic logic is_duty(input logic [ADDR_W-1:0] addr, input int unit);
    logic hit;
    hit = 1'b0;
    if (unit == 0)
    begin
      hit = addr == ADDR_DUTY_UNIT1;
    end
    else if (unit == 1)
    begin
      hit = addr == ADDR_DUTY_UNIT2;
    end
    else if (unit == 2)
    begin
      hit = addr == ADDR_DUTY_UNIT3;
    end
    return hit;
  endfunction

  assign duty_bus = cur.duty;

  pwm_period_gen u_period
  (
    .core_clk(core_clk),
    .rst(rst),
    .period(cur.period),
    .duty(duty_bus),
    .period_start(period_start),
    .raw_a(raw_a)
  );

  genvar g;
  generate
    for (g = 0; g < UNITS; g++)
    begin : gen_unit
      shutdown_pin_ctrl u_pins
      (
        .source_select(cur.ctrl[g][SRC_LSB+2:SRC_LSB]),
        .pair_ac_shutdown_level(cur.ctrl[g][AC_LSB+1:AC_LSB]),
        .pair_bd_shutdown_level(cur.ctrl[g][BD_LSB+1:BD_LSB]),
        .comparator1_result(comparator1_result),
        .comparator2_result(comparator2_result),
        .fault_input_pin(fault_input_pin),
        .latched_shutdown(cur.shutdown_event_flag[g] | cur.hold[g]),
        .raw_a(raw_a[g]),
        .condition(condition[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g])
      );
      // Pins are combinational so a fault reaches them without a clock edge
      assign pwm_out_a[g] = pin_out[g][0];
      assign pwm_out_b[g] = pin_out[g][1];
      assign pwm_out_c[g] = pin_out[g][2];
      assign pwm_out_d[g] = pin_out[g][3];
      assign pwm_out_a_oe[g] = pin_oe[g][0];
      assign pwm_out_b_oe[g] = pin_oe[g][1];
      assign pwm_out_c_oe[g] = pin_oe[g][2];
      assign pwm_out_d_oe[g] = pin_oe[g][3];
    end
  endgenerate

  always_comb
  begin
    logic access;
    logic wr;
    logic [UNITS-1:0] set_evt;
    logic [UNITS-1:0] w1c;
    logic [31:0] rdata;
    access = 1'b0;
    wr = 1'b0;
    set_evt = '0;
    w1c = '0;
    rdata = 32'h0000_0000;
    next_cur = cur;

    // One wait cycle, then the access completes on the edge with waitrequest low
    access = (avs_read | avs_write) & ~cur.waitrequest;
    wr = access & avs_write & avs_byteenable[0];
    case (cur.bus)
      BUS_WAIT:
      begin
        next_cur.waitrequest = 1'b1;
        if (avs_read | avs_write)
        begin
          next_cur.bus = BUS_ACK;
          next_cur.waitrequest = 1'b0;
        end
      end
      BUS_ACK:
      begin
        next_cur.bus = BUS_WAIT;
        next_cur.waitrequest = 1'b1;
      end
      default:
      begin
        next_cur.bus = BUS_WAIT;
        next_cur.waitrequest = 1'b1;
      end
    endcase

    // Read data is prepared during the wait cycle
    for (int u = 0; u < UNITS; u++)
    begin
      if (is_ctrl(avs_address, u))
      begin
        rdata[7:0] = {cur.shutdown_event_flag[u], cur.ctrl[u]};
      end
      else if (is_duty(avs_address, u))
      begin
        rdata[7:0] = cur.duty[u];
      end
    end
    if (avs_address == ADDR_IRQ_STATUS)
    begin
      rdata[UNITS-1:0] = cur.irq_status;
    end
    else if (avs_address == ADDR_IRQ_MASK)
    begin
      rdata[UNITS-1:0] = cur.irq_mask;
    end
    else if (avs_address == ADDR_RESTART_CTRL)
    begin
      rdata[UNITS-1:0] = cur.auto_restart;
    end
    else if (avs_address == ADDR_PERIOD)
    begin
      rdata[7:0] = cur.period;
    end
    if (avs_read & cur.waitrequest)
    begin
      next_cur.readdata = rdata;
    end

    // Register writes
    for (int u = 0; u < UNITS; u++)
    begin
      if (wr && is_ctrl(avs_address, u))
      begin
        next_cur.ctrl[u] = avs_writedata[6:0];
        // Writing one forces a software shutdown; clearing needs a quiet source
        if (!condition[u])
        begin
          next_cur.shutdown_event_flag[u] = avs_writedata[FLAG_BIT];
        end
      end
      if (wr && is_duty(avs_address, u))
      begin
        next_cur.duty[u] = avs_writedata[7:0];
      end
    end
    if (wr && avs_address == ADDR_IRQ_MASK)
    begin
      next_cur.irq_mask = avs_writedata[UNITS-1:0];
    end
    if (wr && avs_address == ADDR_RESTART_CTRL)
    begin
      next_cur.auto_restart = avs_writedata[UNITS-1:0];
    end
    if (wr && avs_address == ADDR_PERIOD)
    begin
      next_cur.period = avs_writedata[7:0];
    end
    if (wr && avs_address == ADDR_IRQ_STATUS)
    begin
      w1c = avs_writedata[UNITS-1:0];
    end

    // Shutdown state per unit
    for (int u = 0; u < UNITS; u++)
    begin
      if (cur.auto_restart[u] && cur.shutdown_event_flag[u] && !condition[u])
      begin
        next_cur.shutdown_event_flag[u] = 1'b0;
      end
      if (condition[u])
      begin
        next_cur.shutdown_event_flag[u] = 1'b1;
        set_evt[u] = ~cur.shutdown_event_flag[u];
      end
      // Pins stay parked until a period boundary after the flag clears
      if (cur.shutdown_event_flag[u] || condition[u])
      begin
        next_cur.hold[u] = 1'b1;
      end
      else if (period_start)
      begin
        next_cur.hold[u] = 1'b0;
      end
    end

    // Sticky events, set beats a simultaneous clear
    next_cur.irq_status = (cur.irq_status & ~w1c) | set_evt;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur.bus <= BUS_WAIT;
      cur.waitrequest <= 1'b1;
      cur.readdata <= 32'h0000_0000;
      cur.ctrl <= '0;
      cur.shutdown_event_flag <= '0;
      cur.hold <= '0;
      cur.irq_status <= '0;
      cur.irq_mask <= '0;
      cur.auto_restart <= '0;
      cur.period <= PERIOD_RESET;
      cur.duty <= {UNITS{DUTY_RESET}};
      cur.irq <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign avs_readdata = cur.readdata;
  assign avs_waitrequest = cur.waitrequest;
  assign irq = cur.irq;
endmodule

/* testbench/power_stage_model.sv */
// Behavioural power stage on unit 1 pins, with its own fault line
`timescale 1ns/1ns
module power_stage_model
(
  // Gate drive, order a, c, b, d
  input wire logic [3:0] gate,
  input wire logic [3:0] gate_oe,
  // Fault request from the bench
  input wire logic trip,
  // Resolved levels and fault line
  output logic [3:0] level,
  output logic fault_n
);
  // An undriven gate floats; the bench sees z, not a stale level
  assign level[0] = gate_oe[0] ? gate[0] : 1'bz;
  assign level[1] = gate_oe[1] ? gate[1] : 1'bz;
  assign level[2] = gate_oe[2] ? gate[2] : 1'bz;
  assign level[3] = gate_oe[3] ? gate[3] : 1'bz;
  // Pull-up keeps the line high outside a fault
  assign fault_n = !trip;
endmodule

/* testbench/pwm_shutdown_sva.sv */
// Assertions on the auto-shutdown block ports
`timescale 1ns/1ns
module pwm_shutdown_sva
  import pwm_shutdown_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Fault sources
  input wire logic comparator1_result,
  input wire logic comparator2_result,
  input wire logic fault_input_pin,
  // Pins and interrupt
  input wire logic [UNITS-1:0] pwm_out_a,
  input wire logic [UNITS-1:0] pwm_out_a_oe,
  input wire logic [UNITS-1:0] pwm_out_b,
  input wire logic [UNITS-1:0] pwm_out_b_oe,
  input wire logic [UNITS-1:0] pwm_out_c,
  input wire logic [UNITS-1:0] pwm_out_c_oe,
  input wire logic [UNITS-1:0] pwm_out_d,
  input wire logic [UNITS-1:0] pwm_out_d_oe,
  input wire logic irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Shadow of unit 1 control and the mask, from completed writes only
  logic [7:0] ctrl;
  logic [UNITS-1:0] mask;
  logic wr_ok, rd_ok, cond;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  assign cond = (ctrl[4] && comparator1_result) || (ctrl[5] && comparator2_result) || (ctrl[6] && !fault_input_pin);
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl <= 8'h00;
      mask <= '0;
    end
    else if (wr_ok && avs_address == ADDR_CTRL_UNIT1)
      ctrl <= avs_writedata[7:0];
    else if (wr_ok && avs_address == ADDR_IRQ_MASK)
      mask <= avs_writedata[UNITS-1:0];
  end
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_AC_DRIVE: assert property (cond && !ctrl[3] |-> pwm_out_a[0] == ctrl[2] && pwm_out_c[0] == ctrl[2]
    && pwm_out_a_oe[0] && pwm_out_c_oe[0]) else $error("a/c pair not at its shutdown level");
  AST_AC_FLOAT: assert property (cond && ctrl[3] |-> !pwm_out_a_oe[0] && !pwm_out_c_oe[0])
    else $error("a/c pair still driven");
  AST_BD_DRIVE: assert property (cond && !ctrl[1] |-> pwm_out_b[0] == ctrl[0] && pwm_out_d[0] == ctrl[0]
    && pwm_out_b_oe[0] && pwm_out_d_oe[0]) else $error("b/d pair not at its shutdown level");
  AST_BD_FLOAT: assert property (cond && ctrl[1] |-> !pwm_out_b_oe[0] && !pwm_out_d_oe[0])
    else $error("b/d pair still driven");
  AST_HOLD: assert property ($past(cond) && !cond && !ctrl[3] && $stable(ctrl) |->
    pwm_out_a[0] == ctrl[2] && pwm_out_a_oe[0]) else $error("pins released as the fault went away");
  AST_FLAG_READ: assert property (rd_ok && avs_address == ADDR_CTRL_UNIT1 && $past(cond, 2) |->
    avs_readdata[7]) else $error("flag reads zero after a fault");
  AST_CTRL_READ: assert property (rd_ok && avs_address == ADDR_CTRL_UNIT1 |->
    avs_readdata[6:0] == ctrl[6:0] && avs_readdata[31:8] == 24'h000000) else $error("control readback wrong");
  AST_HOLE_READ: assert property (rd_ok && avs_address == 16'h0100 |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_IRQ_QUIET: assert property (mask == '0 && $past(mask) == '0 |-> !irq)
    else $error("interrupt with all sources masked");
  cover property (cond && ctrl[3]);
  cover property (cond && !ctrl[1]);
  cover property (irq);
endmodule

/* testbench/pwm_auto_shutdown_test.sv */
// Self-checking bench for the auto-shutdown block
`timescale 1ns/1ns
module pwm_auto_shutdown_test
  import pwm_shutdown_pkg::*;
;
  localparam logic [15:0] ADDR_HOLE = 16'h0100;
  localparam logic [7:0] PER = 8'h03;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, irq, trip;
  logic comparator1_result, comparator2_result, fault_input_pin;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, lvl;
  logic [UNITS-1:0] pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe;
  logic [UNITS-1:0] pwm_out_c, pwm_out_c_oe, pwm_out_d, pwm_out_d_oe;
  int fail_count, compares, cyc;
  pwm_auto_shutdown dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .comparator1_result, .comparator2_result, .fault_input_pin,
    .pwm_out_a, .pwm_out_a_oe, .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe, .pwm_out_d, .pwm_out_d_oe, .irq);
  power_stage_model stage_u (.gate({pwm_out_a[0], pwm_out_c[0], pwm_out_b[0], pwm_out_d[0]}),
    .gate_oe({pwm_out_a_oe[0], pwm_out_c_oe[0], pwm_out_b_oe[0], pwm_out_d_oe[0]}),
    .trip, .level(lvl), .fault_n(fault_input_pin));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register access; request held until waitrequest is seen low
  task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [1:0] pairv(logic [1:0] f);
    return f[1] ? 2'bzz : {f[0], f[0]};
  endfunction
  function automatic logic fires(logic [2:0] s, logic c1, logic c2, logic f);
    return (s[0] && c1) || (s[1] && c2) || (s[2] && !f);
  endfunction
  // Duty zero: a low, b high while running normally
  task norm();
    @(negedge core_clk);
    chk({30'h0, lvl[3], lvl[1]}, 32'h1);
  endtask
  // Remove faults, clear flag and status, wait out one period
  task settle(input logic [7:0] c);
    @(posedge core_clk);
    comparator1_result <= 1'b0;
    comparator2_result <= 1'b0;
    trip <= 1'b0;
    bus(1'b1, ADDR_CTRL_UNIT1, c);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h07);
    repeat (PER + 3) @(posedge core_clk);
  endtask
  task t_reset();
    bus(1'b0, ADDR_CTRL_UNIT1, 8'h00);
    chk(rd, {24'h0, CTRL_RESET});
    bus(1'b0, ADDR_CTRL_UNIT3, 8'h00);
    chk(rd, {24'h0, CTRL_RESET});
    bus(1'b0, ADDR_PERIOD, 8'h00);
    chk(rd, {24'h0, PERIOD_RESET});
    bus(1'b1, ADDR_HOLE, 8'hA5);
    bus(1'b0, ADDR_HOLE, 8'h00);
    chk(rd, 32'h0);
    norm();
    bus(1'b1, ADDR_PERIOD, PER);
    $display("reset test done");
  endtask
  task t_sources();
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 4; k++)
      begin
        bus(1'b1, ADDR_CTRL_UNIT1, {1'b0, s[2:0], 4'h4});
        @(posedge core_clk);
        comparator1_result <= (k == 0);
        comparator2_result <= (k == 1);
        trip <= (k == 2);
        @(negedge core_clk);
        if (fires(s[2:0], k == 0, k == 1, k != 2))
          chk({28'h0, lvl}, 32'hC);
        else
          chk({30'h0, lvl[3], lvl[1]}, 32'h1);
        settle({1'b0, s[2:0], 4'h4});
      end
    $display("source test done");
  endtask
  task t_levels();
    bus(1'b1, ADDR_CTRL_UNIT1, 8'h10);
    @(posedge core_clk);
    comparator1_result <= 1'b1;
    for (int f = 0; f < 16; f++)
    begin
      bus(1'b1, ADDR_CTRL_UNIT1, {4'h1, f[3:0]});
      @(negedge core_clk);
      chk({28'h0, lvl}, {28'h0, pairv(f[3:2]), pairv(f[1:0])});
    end
    bus(1'b0, ADDR_CTRL_UNIT1, 8'h00);
    chk(rd, 32'h9F);
    @(posedge core_clk);
    comparator1_result <= 1'b0;
    @(negedge core_clk);
    chk({28'h0, lvl}, {28'h0, 4'hZ});
    bus(1'b0, ADDR_CTRL_UNIT1, 8'h00);
    chk(rd, 32'h9F);
    settle(8'h1F);
    bus(1'b0, ADDR_CTRL_UNIT1, 8'h00);
    chk(rd, 32'h1F);
    norm();
    $display("level test done");
  endtask
  task t_irq();
    bus(1'b1, ADDR_IRQ_MASK, 8'h01);
    bus(1'b1, ADDR_CTRL_UNIT1, 8'h40);
    @(posedge core_clk);
    trip <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(rd, 32'h1);
    settle(8'h40);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 8'h00);
    @(posedge core_clk);
    trip <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    settle(8'h40);
    $display("interrupt test done");
  endtask
  task t_restart();
    bus(1'b1, ADDR_RESTART_CTRL, 8'h01);
    bus(1'b1, ADDR_CTRL_UNIT1, 8'h20);
    @(posedge core_clk);
    comparator2_result <= 1'b1;
    @(posedge core_clk);
    comparator2_result <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(1'b0, ADDR_CTRL_UNIT1, 8'h00);
    chk(rd, 32'h20);
    repeat (PER + 3) @(posedge core_clk);
    norm();
    $display("restart test done");
  endtask
  // Units 2 and 3 pins, refused byte lane, full duty on unit 1
  task t_units();
    bus(1'b1, ADDR_CTRL_UNIT2, 8'h11);
    bus(1'b1, ADDR_CTRL_UNIT3, 8'h1A);
    bus(1'b1, ADDR_DUTY_UNIT1, 8'h04);
    @(posedge core_clk);
    comparator1_result <= 1'b1;
    @(negedge core_clk);
    chk({28'h0, pwm_out_a[1], pwm_out_c[1], pwm_out_b[1], pwm_out_d[1]}, 32'h3);
    chk({28'h0, pwm_out_a_oe[1], pwm_out_c_oe[1], pwm_out_b_oe[1], pwm_out_d_oe[1]}, 32'hF);
    chk({28'h0, pwm_out_a_oe[2], pwm_out_c_oe[2], pwm_out_b_oe[2], pwm_out_d_oe[2]}, 32'h0);
    chk({30'h0, lvl[3], lvl[1]}, 32'h2);
    @(posedge core_clk);
    avs_byteenable <= 4'hE;
    bus(1'b1, ADDR_CTRL_UNIT3, 8'h00);
    avs_byteenable <= 4'hF;
    bus(1'b0, ADDR_CTRL_UNIT3, 8'h00);
    chk(rd, 32'h9A);
    bus(1'b0, ADDR_CTRL_UNIT2, 8'h00);
    chk(rd, 32'h91);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(rd, 32'h7);
    @(posedge core_clk);
    comparator1_result <= 1'b0;
    $display("unit test done");
  endtask
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    comparator1_result = 1'b0;
    comparator2_result = 1'b0;
    trip = 1'b0;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_levels();
    t_irq();
    t_restart();
    t_units();
    wrap_up();
  end
endmodule
bind pwm_auto_shutdown pwm_shutdown_sva sva_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .comparator1_result, .comparator2_result, .fault_input_pin,
  .pwm_out_a, .pwm_out_a_oe, .pwm_out_b, .pwm_out_b_oe, .pwm_out_c, .pwm_out_c_oe, .pwm_out_d, .pwm_out_d_oe, .irq);
